// [dat_pkg.sv]
package dat_pkg;
  // ==========================================================
  // serial debug port register addresses (A[3:2] as byte addr)
  localparam logic [3:0] DP_ADDR_ID_CTRL = 4'h0;
  localparam logic [3:0] DP_ADDR_CTRL_STAT = 4'h4;
  localparam logic [3:0] DP_ADDR_SELECT = 4'h8;
  localparam logic [3:0] DP_ADDR_RDBUFF = 4'hC;
  // target identity register: printed offset and its bank
  localparam logic [11:0] TARGET_IDENTITY_INFO_OFFSET = 12'h042;
  localparam logic [3:0] TARGET_ID_READ_ADDR = 4'h4;
  localparam logic [3:0] TARGET_ID_BANK = 4'h2;
  // arbitrary identity value
  localparam logic [31:0] TARGET_ID_VALUE = 32'h0000_1001;
  localparam logic [31:0] DP_IDCODE_VALUE = 32'h0000_2001;
  localparam logic [3:0] SWD_VERSION = 4'h1;
  // access port identifiers
  localparam logic [7:0] AP_SYS_BUS = 8'h00;
  localparam logic [7:0] AP_PERIPH_BUS = 8'h03;
  localparam logic [7:0] AP_CONTROL = 8'h04;
  // select register fields
  localparam int SEL_BANK_LSB = 0;
  localparam int SEL_APSEL_LSB = 24;
  // ctrl/stat fields
  localparam int CS_DBG_PWRUP_REQ = 28;
  localparam int CS_SYS_PWRUP_REQ = 30;
  localparam int CS_DBG_PWRUP_ACK = 29;
  localparam int CS_SYS_PWRUP_ACK = 31;
  // swd acknowledge codes (lsb first on the wire)
  localparam logic [2:0] ACK_OK = 3'h1;
  localparam logic [2:0] ACK_WAIT = 3'h2;
  localparam logic [2:0] ACK_FAULT = 3'h4;
  // debug resources
  localparam int BREAKPOINT_COUNT = 8;
  localparam int WATCHPOINT_COUNT = 4;
  // trace port and swd link framing
  localparam int TRACE_WIDTH = 4;
  localparam logic [1:0] TRACE_RATE_RESET = 2'h0;
  localparam logic [1:0] DRIVE_STANDARD = 2'h0;
  localparam logic [1:0] DRIVE_HIGH = 2'h1;
  localparam int LINE_RESET_ONES = 50;
  localparam int SWD_HDR_BITS = 8;
  localparam int SWD_DATA_BITS = 32;
endpackage : dat_pkg

// [dat_trace_buf.sv]
`timescale 1ns/1ps
// ==========================================================
// two-entry skid buffer on the trace data path
module dat_trace_buf #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem_reg [2];
  logic [WIDTH-1:0] mem_next [2];
  logic [1:0] count_reg, count_next;
  logic rdPtr_reg, rdPtr_next, wrPtr_reg, wrPtr_next;
  logic push, pop;

  assign inReady = (count_reg != 2'd2);
  assign outValid = (count_reg != 2'd0);
  assign outData = mem_reg[rdPtr_reg];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    mem_next = mem_reg;
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wrPtr_reg] = inData;
      wrPtr_next = ~wrPtr_reg;
    end
    if (pop) begin
      rdPtr_next = ~rdPtr_reg;
    end
    if (push && !pop) begin
      count_next = count_reg + 2'd1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'd1;
    end
  end

  always_ff @(posedge clk) begin
    mem_reg <= mem_next;
    if (reset) begin
      count_reg <= 2'd0;
      rdPtr_reg <= 1'b0;
      wrPtr_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      rdPtr_reg <= rdPtr_next;
      wrPtr_reg <= wrPtr_next;
    end
  end
endmodule : dat_trace_buf

// [dat_debug_access.sv]
`timescale 1ns/1ps
// Function
// R1 - full access protection set refuses every debugger access regardless of secure setting; code still lets dp registers and control port 4 answer
// R2 - secure protection alone allows only non-secure code, memory and peripherals
// R3 - execute-permitted ram or flash regions stay readable by the debugger
// R4 - port id 0 system bus, 3 peripheral bus, 4 control port
// R5 - debugger raises power-up request before system bus or control port access
// R6 - debug interface mode follows the power-up request level
// R7 - debugger drops power-up request at session end, then pin reset
// R8 - power-up request in off state wakes device and sets wake flag
// R9 - higher priority interrupts keep running while a breakpoint halts lower levels
// R10 - trace data leaves on four data lines with a trace clock
// R11 - retained rate setting chooses trace rate; trace pins share gpio pads
// R12 - trace pads use standard or high drive only, untouched during debugging
// R13 - read of port register 0x4 with bank 0x2 returns target identity
// R14 - eight hardware breakpoint comparators available
// R15 - four data watchpoint comparators available
// R16 - two-pin serial wire debug version 1, device is target
// R17 - target identity is read-only, writes have no effect
module dat_debug_access #(
  parameter int BP_COUNT = dat_pkg::BREAKPOINT_COUNT,
  parameter int WP_COUNT = dat_pkg::WATCHPOINT_COUNT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic swdClkPin,
  input wire logic swdIoIn,
  output logic swdIoOut,
  output logic swdIoOe_n,
  input wire logic fullAccessProtection,
  input wire logic secureDebugProtection,
  input wire logic regionExecAllowed,
  input wire logic regionReadAllowed,
  input wire logic regionSecure,
  input wire logic systemOff,
  input wire logic [1:0] padDrive,
  input wire logic [1:0] traceRateSetting,
  input wire logic traceEnable,
  input wire logic [7:0] traceByte,
  input wire logic traceByteValid,
  output logic traceByteReady,
  input wire logic [3:0] gpioOut,
  input wire logic [7:0] bpHitMask,
  input wire logic [3:0] wpHitMask,
  input wire logic [2:0] haltedPriority,
  input wire logic [2:0] pendingPriority,
  output logic debugInterfaceMode,
  output logic debugInterfaceWakeFlag,
  output logic wakeRequest,
  output logic accessGranted,
  output logic secureAccessGranted,
  output logic regionVisible,
  output logic [2:0] apTarget,
  output logic breakpointHalt,
  output logic interruptServiceAllowed,
  output logic [3:0] traceDataLines,
  output logic traceClockOut,
  output logic tracePadSelect,
  output logic driveOk,
  input wire logic wakeFlagClear
);
  typedef enum {SW_IDLE, SW_HDR, SW_TURN1, SW_ACK, SW_WDATA, SW_RDATA, SW_TURN2} dat_swd_state_t;

  // ==========================================================
  // link sampling: two flops, then edge detect
  logic [2:0] clkSync_reg;
  logic [1:0] ioSync_reg;
  logic risingEdge, fallingEdge, ioBit;
  always_ff @(posedge clk) begin
    if (reset) begin
      clkSync_reg <= 3'h0;
      ioSync_reg <= 2'h3;
    end else begin
      clkSync_reg <= {clkSync_reg[1:0], swdClkPin};
      ioSync_reg <= {ioSync_reg[0], swdIoIn};
    end
  end
  assign risingEdge = clkSync_reg[1] && !clkSync_reg[2];
  assign fallingEdge = !clkSync_reg[1] && clkSync_reg[2];
  assign ioBit = ioSync_reg[1];

  // ==========================================================
  // swd target engine
  dat_swd_state_t state_reg, state_next;
  logic [7:0] hdr_reg, hdr_next;
  logic [32:0] shift_reg, shift_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [31:0] select_reg, select_next;
  logic [31:0] ctrlStat_reg, ctrlStat_next;
  logic [5:0] ones_reg, ones_next;
  logic out_reg, out_next, oe_reg, oe_next;
  logic [2:0] ack_reg, ack_next;
  logic isAp, isRead;
  logic [3:0] addr;
  logic [7:0] apSel;

  function automatic logic parity32(input logic [31:0] v);
    parity32 = ^v;
  endfunction : parity32

  function automatic logic [31:0] dpRead(input logic [3:0] a, input logic [31:0] sel, input logic [31:0] cs);
    dpRead = 32'h0000_0000;
    unique case (a)
      dat_pkg::DP_ADDR_ID_CTRL: dpRead = dat_pkg::DP_IDCODE_VALUE;
      dat_pkg::DP_ADDR_CTRL_STAT: begin
        if (sel[dat_pkg::SEL_BANK_LSB +: 4] == dat_pkg::TARGET_ID_BANK) begin
          dpRead = dat_pkg::TARGET_ID_VALUE; // see R13
        end else begin
          dpRead = cs;
        end
      end
      dat_pkg::DP_ADDR_SELECT: dpRead = sel;
      default: dpRead = 32'h0000_0000;
    endcase
  endfunction : dpRead

  assign isAp = hdr_reg[1];
  assign isRead = hdr_reg[2];
  assign addr = {hdr_reg[4], hdr_reg[3], 2'b00};
  assign apSel = select_reg[dat_pkg::SEL_APSEL_LSB +: 8];

  always_comb begin
    logic apOk;
    apOk = 1'b0;
    state_next = state_reg;
    hdr_next = hdr_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    select_next = select_reg;
    ctrlStat_next = ctrlStat_reg;
    ones_next = ones_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    ack_next = ack_reg;
    // power-up ack mirrors request
    ctrlStat_next[dat_pkg::CS_DBG_PWRUP_ACK] = ctrlStat_reg[dat_pkg::CS_DBG_PWRUP_REQ];
    ctrlStat_next[dat_pkg::CS_SYS_PWRUP_ACK] = ctrlStat_reg[dat_pkg::CS_SYS_PWRUP_REQ];
    // sys bus and control port requests need power; all ap requests except the control port need no full protection
    unique case (apSel)
      dat_pkg::AP_SYS_BUS, dat_pkg::AP_CONTROL: apOk = ctrlStat_reg[dat_pkg::CS_SYS_PWRUP_REQ]; // see R5
      dat_pkg::AP_PERIPH_BUS: apOk = 1'b1;
      default: apOk = 1'b0;
    endcase
    if (apSel != dat_pkg::AP_CONTROL && fullAccessProtection) begin
      apOk = 1'b0; // see R1
    end
    if (risingEdge) begin
      ones_next = ioBit ? ((ones_reg == 6'(dat_pkg::LINE_RESET_ONES)) ? ones_reg : ones_reg + 6'd1) : 6'd0;
      unique case (state_reg)
        SW_IDLE: begin
          if (ioBit) begin
            hdr_next = 8'h01;
            cnt_next = 6'd1;
            state_next = SW_HDR;
          end
        end
        SW_HDR: begin
          hdr_next[cnt_reg[2:0]] = ioBit;
          cnt_next = cnt_reg + 6'd1;
          if (cnt_reg == 6'(dat_pkg::SWD_HDR_BITS - 1)) begin
            state_next = SW_TURN1;
          end
        end
        SW_TURN1: begin
          if (^hdr_reg[4:1] != hdr_reg[5] || hdr_reg[6] || !hdr_reg[7]) begin
            state_next = SW_IDLE; // bad header: no response
          end else begin
            ack_next = (isAp && !apOk) ? dat_pkg::ACK_FAULT : dat_pkg::ACK_OK;
            shift_next = {parity32(dpRead(addr, select_reg, ctrlStat_reg)), dpRead(addr, select_reg, ctrlStat_reg)};
            cnt_next = 6'd0;
            state_next = SW_ACK;
          end
        end
        SW_ACK: begin
          cnt_next = cnt_reg + 6'd1;
          if (cnt_reg == 6'($bits(dat_pkg::ACK_OK) - 1)) begin
            cnt_next = 6'd0;
            if (ack_reg != dat_pkg::ACK_OK) begin
              // refused: swallow the host turnaround before idling
              cnt_next = 6'(dat_pkg::SWD_DATA_BITS + 1);
              state_next = SW_RDATA;
            end else begin
              state_next = isRead ? SW_RDATA : SW_TURN2;
            end
          end
        end
        SW_TURN2: begin
          cnt_next = 6'd0;
          state_next = SW_WDATA;
        end
        SW_WDATA: begin
          shift_next = {ioBit, shift_reg[32:1]};
          cnt_next = cnt_reg + 6'd1;
          if (cnt_reg == 6'(dat_pkg::SWD_DATA_BITS)) begin
            state_next = SW_IDLE;
            if (!isAp && parity32(shift_reg[32:1]) == ioBit) begin
              if (addr == dat_pkg::DP_ADDR_SELECT) begin
                select_next = shift_reg[32:1];
              end else if (addr == dat_pkg::DP_ADDR_CTRL_STAT
                  && select_reg[dat_pkg::SEL_BANK_LSB +: 4] == 4'h0) begin
                ctrlStat_next = shift_reg[32:1]; // see R17
              end
            end
          end
        end
        SW_RDATA: begin
          cnt_next = cnt_reg + 6'd1;
          if (cnt_reg == 6'(dat_pkg::SWD_DATA_BITS + 1)) begin
            state_next = SW_IDLE;
          end
        end
        default: state_next = SW_IDLE;
      endcase
      if (ones_reg == 6'(dat_pkg::LINE_RESET_ONES)) begin
        state_next = SW_IDLE;
      end
    end
    // target drives on falling edges
    if (fallingEdge) begin
      oe_next = 1'b1;
      if (state_reg == SW_ACK) begin
        oe_next = 1'b0;
        out_next = ack_reg[cnt_reg[1:0]]; // see R16
      end else if (state_reg == SW_RDATA && cnt_reg <= 6'(dat_pkg::SWD_DATA_BITS)) begin
        oe_next = 1'b0;
        out_next = shift_reg[cnt_reg];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= SW_IDLE;
      hdr_reg <= 8'h00;
      shift_reg <= 33'h0;
      cnt_reg <= 6'd0;
      select_reg <= 32'h0000_0000;
      ctrlStat_reg <= 32'h0000_0000;
      ones_reg <= 6'd0;
      out_reg <= 1'b1;
      oe_reg <= 1'b1;
      ack_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      hdr_reg <= hdr_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      select_reg <= select_next;
      ctrlStat_reg <= ctrlStat_next;
      ones_reg <= ones_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      ack_reg <= ack_next;
    end
  end
  assign swdIoOut = out_reg;
  assign swdIoOe_n = oe_reg;

  // ==========================================================
  // mode, wake flag, access gating
  logic wake_reg, wake_next, mode_reg, mode_next;
  logic [2:0] apt_reg, apt_next;
  logic pwr;
  assign pwr = ctrlStat_reg[dat_pkg::CS_SYS_PWRUP_REQ] || ctrlStat_reg[dat_pkg::CS_DBG_PWRUP_REQ];
  always_comb begin
    mode_next = pwr; // see R6
    wake_next = wake_reg;
    if (wakeFlagClear) begin
      wake_next = 1'b0;
    end
    if (pwr && systemOff) begin
      wake_next = 1'b1; // see R8
    end
    apt_next = 3'b000;
    unique case (apSel)
      dat_pkg::AP_SYS_BUS: apt_next = 3'b001; // see R4
      dat_pkg::AP_PERIPH_BUS: apt_next = 3'b010;
      dat_pkg::AP_CONTROL: apt_next = 3'b100;
      default: apt_next = 3'b000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_reg <= 1'b0;
      mode_reg <= 1'b0;
      apt_reg <= 3'b000;
    end else begin
      wake_reg <= wake_next;
      mode_reg <= mode_next;
      apt_reg <= apt_next;
    end
  end
  assign debugInterfaceMode = mode_reg;
  assign debugInterfaceWakeFlag = wake_reg;
  assign wakeRequest = pwr && systemOff;
  assign apTarget = apt_reg;
  assign accessGranted = !fullAccessProtection; // see R1
  assign secureAccessGranted = !fullAccessProtection && !secureDebugProtection; // see R2
  assign regionVisible = accessGranted && (regionExecAllowed || regionReadAllowed) // see R3
      && (!regionSecure || secureAccessGranted); // see R2
  assign breakpointHalt = accessGranted && ((|bpHitMask[BP_COUNT-1:0]) || (|wpHitMask[WP_COUNT-1:0])); // see R14
  assign interruptServiceAllowed = !breakpointHalt || (pendingPriority < haltedPriority); // see R9
  assign driveOk = (padDrive == dat_pkg::DRIVE_STANDARD) || (padDrive == dat_pkg::DRIVE_HIGH); // see R12

  // ==========================================================
  // trace port: byte buffer, nibble per trace clock half
  logic bufValid, bufReady;
  logic [7:0] bufData;
  logic [3:0] div_reg, div_next, tdata_reg, tdata_next;
  logic tclk_reg, tclk_next, nib_reg, nib_next;
  dat_trace_buf #(.WIDTH(8)) u_buf (
    .clk(clk),
    .reset(reset),
    .inValid(traceByteValid),
    .inReady(traceByteReady),
    .inData(traceByte),
    .outValid(bufValid),
    .outReady(bufReady),
    .outData(bufData)
  );
  // rate setting n halves clock by 2^(n); each tick moves one nibble
  assign bufReady = traceEnable && nib_reg && (div_reg == 4'h0);
  always_comb begin
    div_next = div_reg - 4'h1;
    tclk_next = tclk_reg;
    tdata_next = tdata_reg;
    nib_next = nib_reg;
    if (div_reg == 4'h0) begin
      div_next = (4'h1 << traceRateSetting) - 4'h1; // see R11
      tclk_next = ~tclk_reg;
      if (traceEnable && bufValid) begin
        tdata_next = nib_reg ? bufData[7:4] : bufData[3:0]; // see R10
        nib_next = ~nib_reg;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      div_reg <= 4'h0;
      tclk_reg <= 1'b0;
      tdata_reg <= 4'h0;
      nib_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tclk_reg <= tclk_next;
      tdata_reg <= tdata_next;
      nib_reg <= nib_next;
    end
  end
  assign tracePadSelect = traceEnable; // see R11
  assign traceDataLines = traceEnable ? tdata_reg : gpioOut;
  assign traceClockOut = traceEnable && tclk_reg;
endmodule : dat_debug_access

// [dat_debug_access_props.sv]
`timescale 1ns/1ps
// ==========================================================
// port checker
module dat_debug_access_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic fullAccessProtection,
  input wire logic secureDebugProtection,
  input wire logic regionExecAllowed,
  input wire logic accessGranted,
  input wire logic secureAccessGranted,
  input wire logic regionVisible,
  input wire logic [1:0] padDrive,
  input wire logic driveOk,
  input wire logic traceEnable,
  input wire logic [3:0] gpioOut,
  input wire logic [3:0] traceDataLines,
  input wire logic [7:0] bpHitMask,
  input wire logic breakpointHalt,
  input wire logic [2:0] haltedPriority,
  input wire logic [2:0] pendingPriority,
  input wire logic interruptServiceAllowed,
  input wire logic [2:0] apTarget,
  input wire logic debugInterfaceWakeFlag,
  input wire logic wakeFlagClear,
  input wire logic traceByteValid,
  input wire logic traceByteReady
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_full;
    fullAccessProtection |-> !accessGranted && !secureAccessGranted && !regionVisible;
  endproperty
  a_full: assert property (p_full) else $error("access granted while protected");
  property p_secure;
    secureDebugProtection |-> !secureAccessGranted;
  endproperty
  a_secure: assert property (p_secure) else $error("secure access granted");
  property p_exec;
    !fullAccessProtection && !secureDebugProtection && regionExecAllowed |-> regionVisible;
  endproperty
  a_exec: assert property (p_exec) else $error("executable region hidden");
  property p_ap;
    $onehot0(apTarget);
  endproperty
  a_ap: assert property (p_ap) else $error("port target not onehot");
  property p_flag;
    debugInterfaceWakeFlag && !wakeFlagClear |=> debugInterfaceWakeFlag;
  endproperty
  a_flag: assert property (p_flag) else $error("wake flag lost");
  property p_irq;
    breakpointHalt && (pendingPriority < haltedPriority) |-> interruptServiceAllowed;
  endproperty
  a_irq: assert property (p_irq) else $error("urgent interrupt blocked");
  property p_drain;
    traceEnable && traceByteValid && !traceByteReady |-> ##[1:80] traceByteReady;
  endproperty
  a_drain: assert property (p_drain) else $error("trace buffer stuck");
  property p_gpio;
    !traceEnable && !$past(traceEnable) && !$past(reset) && $stable(gpioOut) |-> traceDataLines == gpioOut;
  endproperty
  a_gpio: assert property (p_gpio) else $error("pads not showing gpio");
  property p_drive;
    driveOk == (padDrive <= dat_pkg::DRIVE_HIGH);
  endproperty
  a_drive: assert property (p_drive) else $error("drive check wrong");
  property p_halt;
    accessGranted && (|bpHitMask) |-> breakpointHalt;
  endproperty
  a_halt: assert property (p_halt) else $error("breakpoint hit ignored");
  c_wake: cover property ($rose(debugInterfaceWakeFlag));
  c_ctrl: cover property (apTarget == 3'b100);
  c_stall: cover property (traceByteValid && !traceByteReady);
endmodule : dat_debug_access_props

// [dat_swd_probe.sv]
`timescale 1ns/1ps
// ==========================================================
// debugger probe; clock stands low outside frames
module dat_swd_probe (
  output logic swdClk,
  output logic hostIo,
  output logic hostOe,
  input wire logic swdLine
);
  initial begin
    swdClk = 1'b0;
    hostIo = 1'b1;
    hostOe = 1'b0;
  end
  task automatic bit_out(input logic b);
    hostOe = 1'b1;
    hostIo = b;
    #80 swdClk = 1'b1;
    #80 swdClk = 1'b0;
  endtask : bit_out
  // sample late in the high phase, device drives from falling edge
  task automatic bit_in(output logic b);
    hostOe = 1'b0;
    hostIo = ~hostIo;
    #80 swdClk = 1'b1;
    #75 b = swdLine;
    #5 swdClk = 1'b0;
  endtask : bit_in
  task automatic line_reset();
    repeat (56) bit_out(1'b1);
    repeat (2) bit_out(1'b0);
    hostOe = 1'b0;
  endtask : line_reset
  task automatic xfer(input logic ap, input logic rnw, input logic [1:0] a, input logic [31:0] wd,
                      output logic [2:0] ack, output logic [31:0] rd, output logic rpar);
    logic b;
    logic [7:0] hdr;
    hdr = {1'b1, 1'b0, ^{a, rnw, ap}, a[1], a[0], rnw, ap, 1'b1};
    rd = 32'h0000_0000;
    rpar = 1'b0;
    for (int i = 0; i < 8; i++) bit_out(hdr[i]);
    bit_in(b);
    for (int i = 0; i < 3; i++) bit_in(ack[i]);
    if (ack == dat_pkg::ACK_OK && rnw) begin
      for (int i = 0; i < 32; i++) bit_in(rd[i]);
      bit_in(rpar);
      bit_in(b);
    end else if (ack == dat_pkg::ACK_OK) begin
      bit_in(b);
      for (int i = 0; i < 32; i++) bit_out(wd[i]);
      bit_out(^wd);
    end else begin
      bit_in(b);
    end
    repeat (2) bit_out(1'b0);
    hostOe = 1'b0;
  endtask : xfer
endmodule : dat_swd_probe

// [test_debug_access_and_trace_control.sv]
`timescale 1ns/1ps
// ==========================================================
// top bench
module test_debug_access_and_trace_control;
  logic clk = 0, reset = 1, swdClkPin, swdIoOut, swdIoOe_n, hostIo, hostOe, swdLine;
  logic fap = 0, sdp = 0, rex = 0, rrd = 0, rsec = 0, systemOff = 0, traceEnable = 0, tbValid = 0;
  logic wakeFlagClear = 0, tbReady, mode, flag, agr, sagr, vis, halt, isa, tclk, driveOk, prevTc = 0;
  logic [1:0] padDrive = 0, traceRate = 0;
  logic [7:0] traceByte = 0, bpHitMask = 0;
  logic [3:0] gpioOut = 0, wpHitMask = 0, lines;
  logic [2:0] halted = 0, pending = 0, apTarget, ack;
  logic [31:0] rd, r;
  logic rpar, sawStall = 0;
  logic wreq, psel;
  logic [3:0] nibQ[$];
  int err_total = 0, checked = 0, cycles = 0, tcCount = 0, period = 0;
  logic [7:0] ids[3] = '{dat_pkg::AP_SYS_BUS, dat_pkg::AP_PERIPH_BUS, dat_pkg::AP_CONTROL};
  always #10 clk = ~clk;
  assign swdLine = !swdIoOe_n ? swdIoOut : (hostOe ? hostIo : 1'b1);
  dat_debug_access dat_debug_access_inst (.clk(clk), .reset(reset), .swdClkPin(swdClkPin), .swdIoIn(swdLine),
    .swdIoOut(swdIoOut), .swdIoOe_n(swdIoOe_n), .fullAccessProtection(fap), .secureDebugProtection(sdp),
    .regionExecAllowed(rex), .regionReadAllowed(rrd), .regionSecure(rsec), .systemOff(systemOff),
    .padDrive(padDrive), .traceRateSetting(traceRate), .traceEnable(traceEnable), .traceByte(traceByte),
    .traceByteValid(tbValid), .traceByteReady(tbReady), .gpioOut(gpioOut), .bpHitMask(bpHitMask),
    .wpHitMask(wpHitMask), .haltedPriority(halted), .pendingPriority(pending), .debugInterfaceMode(mode),
    .debugInterfaceWakeFlag(flag), .wakeRequest(wreq), .accessGranted(agr), .secureAccessGranted(sagr),
    .regionVisible(vis), .apTarget(apTarget), .breakpointHalt(halt), .interruptServiceAllowed(isa),
    .traceDataLines(lines), .traceClockOut(tclk), .tracePadSelect(psel), .driveOk(driveOk),
    .wakeFlagClear(wakeFlagClear));
  dat_swd_probe dat_swd_probe_inst (.swdClk(swdClkPin), .hostIo(hostIo), .hostOe(hostOe), .swdLine(swdLine));
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : compare
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic swd(input logic ap, input logic rnw, input logic [1:0] a, input logic [31:0] wd);
    dat_swd_probe_inst.xfer(ap, rnw, a, wd, ack, rd, rpar);
    @(negedge clk);
  endtask : swd
  task automatic send(input logic [7:0] b);
    traceByte <= b;
    tbValid <= 1'b1;
    @(negedge clk);
    while (tbReady !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask : send
  function automatic logic found();
    for (int s = 0; s + 12 <= nibQ.size(); s++) begin
      logic ok;
      ok = 1'b1;
      for (int k = 0; k < 12; k++) ok &= nibQ[s + k] == ((8'h21 + 8'h22 * (k / 2)) >> (4 * (k % 2))) % 16;
      if (ok) return 1'b1;
    end
    return 1'b0;
  endfunction : found
  always @(posedge clk) begin
    cycles <= cycles + 1;
    prevTc <= tclk;
    tcCount <= tcCount + 1;
    if (tclk && !prevTc) begin
      period <= tcCount;
      tcCount <= 1;
    end
    if (traceEnable && (nibQ.size() == 0 || lines !== nibQ[$])) nibQ.push_back(lines);
    if (cycles > 50000) begin
      err_total++;
      tally_and_finish();
    end
  end
  always @(negedge clk) if (tbValid && tbReady === 1'b0) sawStall = 1'b1;
  initial begin
    void'($urandom(33));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      r = $urandom;
      {fap, sdp, rex, rrd, rsec, padDrive, gpioOut} <= r[10:0];
      bpHitMask <= (i < 8) ? 8'h01 << i : (r[11] ? r[19:12] : 8'h00);
      wpHitMask <= r[23:20] & {4{r[24]}};
      {halted, pending} <= r[30:25];
      @(posedge clk);
      @(negedge clk);
      compare(agr, !fap);
      compare(sagr, !(fap | sdp));
      compare(vis, !fap && (!rsec || !sdp) && (rex || rrd));
      compare(driveOk, padDrive <= dat_pkg::DRIVE_HIGH);
      compare(lines, gpioOut);
      compare(psel, 1'b0);
      compare(halt, !fap && (bpHitMask != 0 || wpHitMask != 0));
      compare(isa, !(!fap && (bpHitMask != 0 || wpHitMask != 0)) || pending < halted);
    end
    @(posedge clk);
    {fap, sdp, systemOff} <= 3'b001;
    @(negedge clk);
    dat_swd_probe_inst.line_reset();
    swd(0, 1, 0, 0);
    compare(rd, dat_pkg::DP_IDCODE_VALUE);
    compare(rpar, ^dat_pkg::DP_IDCODE_VALUE);
    swd(0, 0, 2, 32'h0000_0002);
    compare(ack, dat_pkg::ACK_OK);
    swd(0, 1, 1, 0);
    compare(rd, dat_pkg::TARGET_ID_VALUE);
    swd(0, 0, 1, 32'hFFFF_FFFF);
    swd(0, 1, 1, 0);
    compare(rd, dat_pkg::TARGET_ID_VALUE);
    for (int k = 0; k < 3; k++) begin
      swd(0, 0, 2, {ids[k], 24'h00_0000});
      compare(apTarget, 3'b001 << k);
    end
    swd(0, 0, 1, 32'h5000_0000);
    compare({mode, flag}, 2'b11);
    compare(wreq, 1'b1);
    @(posedge clk);
    systemOff <= 1'b0;
    wakeFlagClear <= 1'b1;
    @(posedge clk);
    wakeFlagClear <= 1'b0;
    swd(1, 1, 0, 0);
    compare({flag, ack}, {1'b0, dat_pkg::ACK_OK});
    compare(wreq, 1'b0);
    swd(0, 0, 1, 0);
    compare(mode, 1'b0);
    swd(1, 1, 0, 0);
    compare(ack, dat_pkg::ACK_FAULT);
    @(posedge clk);
    traceEnable <= 1'b1;
    for (int rate = 0; rate < 4; rate++) begin
      traceRate <= 2'(rate);
      nibQ.delete();
      sawStall = 1'b0;
      for (int j = 0; j < 6; j++) send(8'h21 + 8'h22 * j);
      tbValid <= 1'b0;
      for (int w = 0; w < 2000 && !found(); w++) @(posedge clk);
      compare(found(), 1'b1);
      compare(period, 2 << rate);
      compare(psel, 1'b1);
      if (rate == 3) compare(sawStall, 1'b1);
    end
    tally_and_finish();
  end
endmodule : test_debug_access_and_trace_control
bind dat_debug_access dat_debug_access_props dat_debug_access_props_inst (.clk, .reset, .fullAccessProtection,
  .secureDebugProtection, .regionExecAllowed, .accessGranted, .secureAccessGranted, .regionVisible, .padDrive,
  .driveOk, .traceEnable, .gpioOut, .traceDataLines, .bpHitMask, .breakpointHalt, .haltedPriority,
  .pendingPriority, .interruptServiceAllowed, .apTarget, .debugInterfaceWakeFlag, .wakeFlagClear,
  .traceByteValid, .traceByteReady);
